// ==== hw/sid_top.sv ====
// Step interpolator with standstill detection and diagnostic pins
`timescale 1ns/1ps
// How it works
// - Up to 256 microsteps interpolated per active edge
// - One to 256 microsteps per input step
// - Interpolate only while interp_enable set
// - Previous period split into equal sub-intervals
// - No edge for 2^20 clocks sets still_flag
// - fast_still_detect shortens timeout to 2^18
// - Standstill selects hold_current_level
// - Next active edge clears still_flag
// - Rate change adapts; leftover microsteps dropped
// - Pin selection and output type configurable
// - status_pin_zero low during reset
// - Selectable stall output on diagnostic pin
// - Index asserts at microstep zero
// - Index lasts one microstep, maybe many clocks
// - Chopper on-state alternates between coils
// - Skipped-step output toggles per skipped step
// - Controller mode shows compare and interrupt
// - target_hit_event set at reset
// - dual_edge_step makes both edges active
module sid_top #(
  parameter int unsigned STILL_CYCLES = sid_pkg::STILL_CLKS, // Standstill timeout
  parameter int unsigned FAST_CYCLES = sid_pkg::FAST_CLKS // Fast timeout
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [sid_pkg::ADDR_W-1:0] addr_i,
  input wire logic [sid_pkg::DATA_W-1:0] wr_data_i,
  input wire logic wr_en_i,
  input wire logic rd_en_i,
  output logic [sid_pkg::DATA_W-1:0] rd_data_o,
  input wire logic motion_pulse_in_i,
  input wire logic direction_i,
  input wire logic external_pulse_select_i,
  input wire logic stall_i,
  input wire logic chop_on_a_i,
  input wire logic chop_on_b_i,
  input wire logic skip_step_i,
  input wire logic pos_compare_i,
  input wire logic ramp_irq_i,
  output logic [sid_pkg::MS_W-1:0] microstep_cnt_o,
  output logic [sid_pkg::LVL_W-1:0] coil_level_o,
  output logic still_o,
  output logic status_pin_zero_o,
  output logic status_pin_zero_oe_o,
  output logic status_pin_one_o,
  output logic status_pin_one_oe_o
);
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  localparam int unsigned CW = $clog2(STILL_CYCLES) + 1; // Interval counter width
  localparam logic [CW-1:0] TMO_SLOW = CW'(STILL_CYCLES);
  localparam logic [CW-1:0] TMO_FAST = CW'(FAST_CYCLES);

  typedef struct packed {
    logic [2:0] step_s; // Pin synchroniser, bit 0 first
    logic [2:0] dir_s;
    logic [2:0] sel_s;
    logic step_lvl; // Accepted step level
    logic dir_lvl; // Accepted direction
    logic sel_lvl; // Accepted mode pin, high is step/dir mode
    logic [CW-1:0] per; // Clocks since last active edge
    logic [CW-1:0] last_per; // Previous step interval
    logic [CW-1:0] sub; // Clocks into current sub-interval
    logic [sid_pkg::REM_W-1:0] remain; // Microsteps still to issue
    logic [sid_pkg::MS_W-1:0] mscnt; // Microstep counter
    logic still; // still_flag
    logic target_hit; // target_hit_event
    logic reset_flag; // Set by reset, cleared by software
    logic skip_tgl; // Skipped-step toggle
    logic chop_alt; // Coil shown on chopper output
    logic chop_prev; // Previous shown on-state
    logic [11:0] gcfg; // global_config_reg
    logic [9:0] ccfg; // chopper_config_reg
    logic [sid_pkg::LVL_W-1:0] run_lvl;
    logic [sid_pkg::LVL_W-1:0] hold_lvl; // hold_current_level
    logic [sid_pkg::LVL_W-1:0] coil;
    logic [sid_pkg::DATA_W-1:0] rdata;
    logic p0_o;
    logic p0_oe;
    logic p1_o;
    logic p1_oe;
  } sid_state_t;

  sid_state_t q, d;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Advance the sequencer by amount, backwards when dir is high
  function automatic logic [sid_pkg::MS_W-1:0] sid_advance(
    input logic [sid_pkg::MS_W-1:0] cnt,
    input logic dir,
    input logic [sid_pkg::MS_W-1:0] amount
  );
    sid_advance = dir ? cnt - amount : cnt + amount;
  endfunction

  // Pin driver: returns {level, enable}; open drain pulls low when active
  function automatic logic [1:0] sid_drive(input logic active, input logic pp);
    sid_drive = pp ? {active, 1'b1} : {1'b0, active};
  endfunction

  // Combinational views of the state
  logic edge_act; // Active step edge this cycle
  logic rise;
  logic fall;
  logic interp;
  logic [sid_pkg::RES_W-1:0] res;
  logic [sid_pkg::REM_W-1:0] step_size;
  logic [CW-1:0] interval;
  logic [CW-1:0] tmo;
  logic index;
  logic chop_show;
  logic [3:0] src;
  logic act0;
  logic act1;

  always_comb
  begin
    // Edge is counted only once the last two stages agree
    rise = q.step_s[1] & q.step_s[2] & ~q.step_lvl;
    fall = ~q.step_s[1] & ~q.step_s[2] & q.step_lvl;
    edge_act = rise | (fall & q.ccfg[sid_pkg::CC_DEDGE]);
    interp = q.ccfg[sid_pkg::CC_INTERP];
    // Resolution beyond fullstep is clamped
    res = (q.ccfg[sid_pkg::CC_RES +: sid_pkg::RES_W] > sid_pkg::RES_W'(sid_pkg::MAX_RES))
        ? sid_pkg::RES_W'(sid_pkg::MAX_RES) : q.ccfg[sid_pkg::CC_RES +: sid_pkg::RES_W];
    step_size = sid_pkg::REM_W'(1) << res;
    interval = q.last_per >> res;
    tmo = q.gcfg[sid_pkg::GC_FAST_STILL] ? TMO_FAST : TMO_SLOW;
    index = (q.mscnt == '0);
    // Only the two chopper modes that have a clear on phase are shown
    chop_show = ((q.ccfg[sid_pkg::CC_CHOP +: sid_pkg::CHOP_W] == sid_pkg::CHOP_CYCLE)
              || (q.ccfg[sid_pkg::CC_CHOP +: sid_pkg::CHOP_W] == sid_pkg::CHOP_TOFF))
              && (q.chop_alt ? chop_on_b_i : chop_on_a_i);
    src = '0;
    src[sid_pkg::SRC_STALL] = stall_i;
    src[sid_pkg::SRC_INDEX] = index;
    src[sid_pkg::SRC_CHOP] = chop_show;
    src[sid_pkg::SRC_SKIP] = q.skip_tgl;
    // Step/dir mode uses the masks, controller mode the fixed sources
    if (q.sel_lvl)
    begin
      act0 = |(src & q.gcfg[sid_pkg::GC_PIN0_SEL +: sid_pkg::SEL_W]);
      act1 = |(src & q.gcfg[sid_pkg::GC_PIN1_SEL +: sid_pkg::SEL_W]);
    end
    else
    begin
      act0 = q.target_hit;
      act1 = ramp_irq_i;
    end
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    d = q;
    // Three-stage synchronisers for pins
    d.step_s = {q.step_s[1:0], motion_pulse_in_i};
    d.dir_s = {q.dir_s[1:0], direction_i};
    d.sel_s = {q.sel_s[1:0], external_pulse_select_i};
    if (q.step_s[1] == q.step_s[2])
    begin
      d.step_lvl = q.step_s[2];
    end
    if (q.dir_s[1] == q.dir_s[2])
    begin
      d.dir_lvl = q.dir_s[2];
    end
    if (q.sel_s[1] == q.sel_s[2])
    begin
      d.sel_lvl = q.sel_s[2];
    end
    // Interval counter: restart on edge, saturate at the timeout
    if (edge_act)
    begin
      d.per = '0;
      d.last_per = q.per;
      d.still = 1'b0;
    end
    else if (q.per < tmo)
    begin
      d.per = q.per + CW'(1);
      if (q.per + CW'(1) >= tmo)
      begin
        d.still = 1'b1;
      end
    end
    else
    begin
      d.still = 1'b1; // Timeout shortened while already past it
    end
    // Sequencer
    if (edge_act && interp)
    begin
      // Leftovers from the old rate are dropped on purpose
      d.remain = step_size;
      d.sub = '0;
    end
    else if (edge_act)
    begin
      d.remain = '0;
      d.mscnt = sid_advance(q.mscnt, q.dir_lvl, sid_pkg::MS_W'(step_size));
    end
    else if (!interp)
    begin
      d.remain = '0; // Pending steps die when interpolation stops
    end
    else if (q.remain != '0)
    begin
      // Interval zero means one microstep per clock
      if (q.sub + CW'(1) >= interval)
      begin
        d.sub = '0;
        d.remain = q.remain - sid_pkg::REM_W'(1);
        d.mscnt = sid_advance(q.mscnt, q.dir_lvl, sid_pkg::MS_W'(1));
      end
      else
      begin
        d.sub = q.sub + CW'(1);
      end
    end
    // Coil level follows the next standstill state
    d.coil = d.still ? q.hold_lvl : q.run_lvl;
    // Skipped-step toggle
    if (skip_step_i)
    begin
      d.skip_tgl = ~q.skip_tgl;
    end
    // Alternate coils at the end of each shown on phase
    d.chop_prev = q.chop_alt ? chop_on_b_i : chop_on_a_i;
    if (q.chop_prev && !d.chop_prev)
    begin
      d.chop_alt = ~q.chop_alt;
    end
    // Register reads, one cycle later; unmapped reads give zero
    d.rdata = '0;
    if (rd_en_i)
    begin
      unique case (addr_i)
        sid_pkg::ADDR_GLOBAL_CFG: d.rdata = sid_pkg::DATA_W'(q.gcfg);
        sid_pkg::ADDR_CHOP_CFG: d.rdata = sid_pkg::DATA_W'(q.ccfg);
        sid_pkg::ADDR_CURRENT:
        begin
          d.rdata[sid_pkg::CUR_RUN +: sid_pkg::LVL_W] = q.run_lvl;
          d.rdata[sid_pkg::CUR_HOLD +: sid_pkg::LVL_W] = q.hold_lvl;
        end
        sid_pkg::ADDR_STATUS:
        begin
          d.rdata[sid_pkg::ST_STILL] = q.still;
          d.rdata[sid_pkg::ST_TARGET] = q.target_hit;
          d.rdata[sid_pkg::ST_RESET] = q.reset_flag;
          d.rdata[sid_pkg::ST_MSCNT +: sid_pkg::MS_W] = q.mscnt;
        end
        default: d.rdata = '0;
      endcase
    end
    // Register writes; write one clears, but a new event wins
    if (wr_en_i)
    begin
      unique case (addr_i)
        sid_pkg::ADDR_GLOBAL_CFG: d.gcfg = wr_data_i[11:0];
        sid_pkg::ADDR_CHOP_CFG: d.ccfg = wr_data_i[9:0];
        sid_pkg::ADDR_CURRENT:
        begin
          d.run_lvl = wr_data_i[sid_pkg::CUR_RUN +: sid_pkg::LVL_W];
          d.hold_lvl = wr_data_i[sid_pkg::CUR_HOLD +: sid_pkg::LVL_W];
        end
        sid_pkg::ADDR_STATUS:
        begin
          if (wr_data_i[sid_pkg::ST_TARGET])
          begin
            d.target_hit = 1'b0;
          end
          if (wr_data_i[sid_pkg::ST_RESET])
          begin
            d.reset_flag = 1'b0;
          end
        end
        default: d = d; // Unmapped writes are ignored
      endcase
    end
    if (pos_compare_i)
    begin
      d.target_hit = 1'b1;
    end
    // Pin drivers
    {d.p0_o, d.p0_oe} = sid_drive(act0, q.gcfg[sid_pkg::GC_PIN0_PP]);
    {d.p1_o, d.p1_oe} = sid_drive(act1, q.gcfg[sid_pkg::GC_PIN1_PP]);
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  // Reset pulls pin zero low and sets both event flags
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      q <= '0;
      q.p0_o <= 1'b0;
      q.p0_oe <= 1'b1;
      q.target_hit <= 1'b1;
      q.reset_flag <= 1'b1;
      // Mode reads as controller until the pin settles, so pin zero never blinks
      q.ccfg <= {2'h0, sid_pkg::RES_RST, 3'h0, 1'b1};
      q.run_lvl <= sid_pkg::RUN_RST;
      q.hold_lvl <= sid_pkg::HOLD_RST;
      q.coil <= sid_pkg::RUN_RST;
    end
    else
    begin
      q <= d;
    end
  end

  assign rd_data_o = q.rdata;
  assign microstep_cnt_o = q.mscnt;
  assign coil_level_o = q.coil;
  assign still_o = q.still;
  assign status_pin_zero_o = q.p0_o;
  assign status_pin_zero_oe_o = q.p0_oe;
  assign status_pin_one_o = q.p1_o;
  assign status_pin_one_oe_o = q.p1_oe;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  property p_still_set;
    @(posedge clk_i) disable iff (!rst_n_i)
    (!edge_act && q.per + CW'(1) == tmo && q.per < tmo) |=> q.still;
  endproperty
  a_still_set: assert property (p_still_set) else $error("still_flag not set");

  property p_still_clr;
    @(posedge clk_i) disable iff (!rst_n_i)
    (edge_act && q.still) |=> (!q.still && q.per == '0);
  endproperty
  a_still_clr: assert property (p_still_clr) else $error("still_flag not cleared");

  property p_sat;
    @(posedge clk_i) disable iff (!rst_n_i)
    (q.per <= TMO_SLOW);
  endproperty
  a_sat: assert property (p_sat) else $error("interval counter overran");

  property p_direct;
    @(posedge clk_i) disable iff (!rst_n_i)
    (edge_act && !interp && !q.dir_lvl) |=>
      q.mscnt == $past(q.mscnt) + sid_pkg::MS_W'($past(step_size));
  endproperty
  a_direct: assert property (p_direct) else $error("direct step wrong");

  property p_load;
    @(posedge clk_i) disable iff (!rst_n_i)
    (edge_act && interp) |=> (q.remain == $past(step_size) && q.mscnt == $past(q.mscnt));
  endproperty
  a_load: assert property (p_load) else $error("interpolation not reloaded");

  property p_hold;
    @(posedge clk_i) disable iff (!rst_n_i)
    q.still && $stable(q.hold_lvl) && $past(q.still) |-> coil_level_o == q.hold_lvl;
  endproperty
  a_hold: assert property (p_hold) else $error("hold level not applied");

  property p_rst_pin;
    @(posedge clk_i) disable iff (!rst_n_i)
    $rose(rst_n_i) |-> (status_pin_zero_oe_o && !status_pin_zero_o);
  endproperty
  a_rst_pin: assert property (p_rst_pin) else $error("pin zero not low at reset");

  property p_skip;
    @(posedge clk_i) disable iff (!rst_n_i)
    skip_step_i |=> q.skip_tgl != $past(q.skip_tgl);
  endproperty
  a_skip: assert property (p_skip) else $error("skip toggle missed");

  property p_index;
    @(posedge clk_i) disable iff (!rst_n_i)
    (q.sel_lvl && q.gcfg[sid_pkg::GC_PIN1_SEL +: sid_pkg::SEL_W] == 4'h2 && q.mscnt == '0)
      |=> (status_pin_one_oe_o && status_pin_one_o == $past(q.gcfg[sid_pkg::GC_PIN1_PP]));
  endproperty
  a_index: assert property (p_index) else $error("index not shown");

  c_still: cover property (@(posedge clk_i) disable iff (!rst_n_i) q.still ##1 edge_act);
  c_interp: cover property (@(posedge clk_i) disable iff (!rst_n_i)
    interp && edge_act && q.remain != '0);
  c_wrap: cover property (@(posedge clk_i) disable iff (!rst_n_i) $rose(index));
endmodule

// ==== hw/sid_pkg.sv ====
// Shared constants for the step interpolator and diagnostic pin block
package sid_pkg;
  // ----------------------------------------------------------------
  // Register bus geometry
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W = 8; // Byte address width
  localparam int unsigned DATA_W = 32; // Register data width
  // ----------------------------------------------------------------
  // Register byte addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_GLOBAL_CFG = 8'h00; // global_config_reg
  localparam logic [7:0] ADDR_CHOP_CFG = 8'h04; // chopper_config_reg
  localparam logic [7:0] ADDR_CURRENT = 8'h08; // Run and hold levels
  localparam logic [7:0] ADDR_STATUS = 8'h0C; // Flags and microstep count
  // ----------------------------------------------------------------
  // global_config_reg fields
  // ----------------------------------------------------------------
  localparam int unsigned GC_FAST_STILL = 0; // fast_still_detect
  localparam int unsigned GC_PIN0_PP = 1; // Pin zero push-pull
  localparam int unsigned GC_PIN1_PP = 2; // Pin one push-pull
  localparam int unsigned GC_PIN0_SEL = 4; // Pin zero select mask, 4 bits
  localparam int unsigned GC_PIN1_SEL = 8; // Pin one select mask, 4 bits
  localparam int unsigned SEL_W = 4; // Select mask width
  // ----------------------------------------------------------------
  // chopper_config_reg fields
  // ----------------------------------------------------------------
  localparam int unsigned CC_INTERP = 0; // interp_enable
  localparam int unsigned CC_DEDGE = 1; // dual_edge_step
  localparam int unsigned CC_RES = 4; // Input resolution shift, 4 bits
  localparam int unsigned CC_CHOP = 8; // Chopper mode, 2 bits
  localparam int unsigned RES_W = 4; // Resolution shift width
  localparam int unsigned CHOP_W = 2; // Chopper mode width
  // ----------------------------------------------------------------
  // Current and status fields
  // ----------------------------------------------------------------
  localparam int unsigned LVL_W = 5; // Current level width
  localparam int unsigned CUR_RUN = 0; // Run level position
  localparam int unsigned CUR_HOLD = 8; // hold_current_level position
  localparam int unsigned ST_STILL = 0; // still_flag
  localparam int unsigned ST_TARGET = 1; // target_hit_event, write one to clear
  localparam int unsigned ST_RESET = 2; // Reset flag, write one to clear
  localparam int unsigned ST_MSCNT = 16; // Microstep counter position
  // ----------------------------------------------------------------
  // Sequencer and timing
  // ----------------------------------------------------------------
  localparam int unsigned MS_W = 10; // Microstep counter width
  localparam int unsigned REM_W = 9; // Pending microsteps, up to 256
  localparam int unsigned MAX_RES = 8; // Shift for fullstep input
  localparam int unsigned STILL_CLKS = 1 << 20; // Standstill timeout
  localparam int unsigned FAST_CLKS = 1 << 18; // Shortened timeout
  // ----------------------------------------------------------------
  // Reset values and chopper modes
  // ----------------------------------------------------------------
  localparam logic [3:0] RES_RST = 4'h0; // 256 microstep input
  localparam logic [4:0] RUN_RST = 5'h1F; // Full run level
  localparam logic [4:0] HOLD_RST = 5'h08; // Reduced hold level
  localparam logic [1:0] CHOP_CYCLE = 2'h0; // Cycle-based chopper
  localparam logic [1:0] CHOP_TOFF = 2'h1; // Constant off-time chopper
  // Diagnostic source bits within a select mask
  localparam int unsigned SRC_STALL = 0;
  localparam int unsigned SRC_INDEX = 1;
  localparam int unsigned SRC_CHOP = 2;
  localparam int unsigned SRC_SKIP = 3;
endpackage

// ==== dv/sid_step_src.sv ====
// Step and direction source standing in for the external motion controller
`timescale 1ns/1ps
module sid_step_src (
  input wire logic clk_i,
  input wire logic go_i,
  input wire logic dir_in_i,
  input wire logic [7:0] half_i,
  input wire logic [7:0] count_i,
  output logic step_o,
  output logic dir_o,
  output logic [7:0] left_o
);
  // ----------------------------------------------------------------
  // Pulse train
  // ----------------------------------------------------------------
  logic [7:0] tick_q; // Clocks left in the current half period
  initial
  begin
    step_o = 1'h0;
    dir_o = 1'h0;
    left_o = 8'h00;
    tick_q = 8'h00;
  end
  // Equal halves keep a 50% duty, so dual edges stay evenly spaced
  always @(posedge clk_i)
  begin
    if (go_i)
    begin
      // Direction settles a whole low half before the first edge
      dir_o <= dir_in_i;
      left_o <= count_i;
      tick_q <= half_i;
    end
    else if (left_o != 8'h00)
    begin
      if (tick_q > 8'h01)
      begin
        tick_q <= tick_q - 8'h01;
      end
      else
      begin
        tick_q <= half_i;
        step_o <= ~step_o;
        // A pulse is spent once its falling edge is out; idle level is low
        if (step_o)
        begin
          left_o <= left_o - 8'h01;
        end
      end
    end
  end
endmodule

// ==== dv/sid_top_tb_top.sv ====
// Self-checking bench for the step interpolator and its diagnostic pins
`timescale 1ns/1ps
module sid_top_tb_top;
  // ----------------------------------------------------------------
  // Signals and tables
  // ----------------------------------------------------------------
  typedef struct {logic [7:0] a; logic [31:0] w; logic [31:0] e;} sid_row_t;
  logic clk_i = 1'h0;
  logic rst_n_i = 1'h0; // Opening reset
  logic [7:0] addr_i = 8'h00;
  logic [31:0] wr_data_i = 32'h0000_0000;
  logic wr_en_i = 1'h0;
  logic rd_en_i = 1'h0;
  logic sel_i = 1'h1; // Step and direction mode
  logic stall_i = 1'h0;
  logic chop_i = 1'h0; // Feeds both coil choppers
  logic skip_i = 1'h0;
  logic cmp_i = 1'h0;
  logic irq_i = 1'h0;
  logic go_i = 1'h0;
  logic dir_in_i = 1'h0;
  logic [7:0] half_i = 8'h04;
  logic [7:0] cnt_i = 8'h01;
  logic step, dir, still, p0, p0_oe, p1, p1_oe;
  logic [7:0] left;
  logic [31:0] rd_data_o, d;
  logic [9:0] ms, m0, m1;
  logic [4:0] coil;
  int fails = 0;
  int n_tests = 0;
  int cyc = 0;
  int t0 = 0;
  int k;
  // Write, then read back; bits above fields and unmapped addresses read 0
  sid_row_t rows [7] = '{'{8'h00, 32'hFFFF_FFFF, 32'h0000_0FFF},
    '{8'h04, 32'hFFFF_FD7F, 32'h0000_017F}, '{8'h08, 32'hFFFF_FFFF, 32'h0000_1F1F},
    '{8'h10, 32'hFFFF_FFFF, 32'h0000_0000}, '{8'h00, 32'h0000_0000, 32'h0000_0000},
    '{8'h04, 32'h0000_0030, 32'h0000_0030}, '{8'h08, 32'h0000_0810, 32'h0000_0810}};
  // Direct stepping: config, direction, counter afterwards
  logic [31:0] cfg [5] = '{32'h0000_0030, 32'h0000_0080, 32'h0000_0082, 32'h0000_0080,
    32'h0000_0030};
  logic [4:0] dirs = 5'h1A;
  logic [9:0] exp_ms [5] = '{10'h008, 10'h308, 10'h108, 10'h008, 10'h000};
  // Short timeouts keep the run brief
  sid_top #(.STILL_CYCLES(512), .FAST_CYCLES(128)) sid_top_inst (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wr_data_i(wr_data_i),
    .wr_en_i(wr_en_i), .rd_en_i(rd_en_i), .rd_data_o(rd_data_o),
    .motion_pulse_in_i(step), .direction_i(dir), .external_pulse_select_i(sel_i),
    .stall_i(stall_i), .chop_on_a_i(chop_i), .chop_on_b_i(chop_i), .skip_step_i(skip_i),
    .pos_compare_i(cmp_i), .ramp_irq_i(irq_i), .microstep_cnt_o(ms), .coil_level_o(coil),
    .still_o(still), .status_pin_zero_o(p0), .status_pin_zero_oe_o(p0_oe),
    .status_pin_one_o(p1), .status_pin_one_oe_o(p1_oe));
  sid_step_src sid_step_src_inst (.clk_i(clk_i), .go_i(go_i), .dir_in_i(dir_in_i),
    .half_i(half_i), .count_i(cnt_i), .step_o(step), .dir_o(dir), .left_o(left));
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  always #2 clk_i = ~clk_i;
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  // Wait until n cycles have passed since t0
  task automatic upto(input int n);
    while (cyc - t0 < n) tick(1);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] w);
    @(posedge clk_i);
    addr_i <= a;
    wr_data_i <= w;
    wr_en_i <= 1'h1;
    @(posedge clk_i);
    wr_en_i <= 1'h0;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk_i);
    addr_i <= a;
    rd_en_i <= 1'h1;
    @(posedge clk_i);
    rd_en_i <= 1'h0;
    #1;
    v = rd_data_o;
  endtask
  // Returns at the falling edge of the last pulse
  task automatic pulses(input logic dr, input logic [7:0] h, input logic [7:0] n);
    @(posedge clk_i);
    dir_in_i <= dr;
    half_i <= h;
    cnt_i <= n;
    go_i <= 1'h1;
    @(posedge clk_i);
    go_i <= 1'h0;
    #1;
    for (int i = 0; i < 3000 && left != 8'h00; i++) tick(1);
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      fails++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop();
    $display("Comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
    begin
      $display("verification passed");
    end
    else
    begin
      $display("verification failed");
    end
    $finish;
  endtask
  // Hang guard, well above the expected run length
  always @(posedge clk_i)
  begin
    cyc <= cyc + 1;
    if (cyc == 6000)
    begin
      fails++;
      report_and_stop();
    end
  end
  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial
  begin
    repeat (16) @(posedge clk_i);
    rst_n_i <= 1'h1;
    foreach (rows[i])
    begin
      wr(rows[i].a, rows[i].w);
      rd(rows[i].a, d);
      chk(d, rows[i].e);
    end
    // Pin zero push-pull, pin one open drain, both showing index
    wr(8'h00, 32'h0000_0222);
    foreach (cfg[i])
    begin
      wr(8'h04, cfg[i]);
      pulses(dirs[i], 8'h04, 8'h01);
      tick(8);
      chk(ms, exp_ms[i]);
    end
    chk({p0, p0_oe, p1, p1_oe}, 4'hD);
    pulses(1'h0, 8'h04, 8'h01);
    tick(8);
    chk({p0, p0_oe, p1_oe}, 3'h2);
    // Interpolation, 16 microsteps per input step
    wr(8'h04, 32'h0000_0041);
    wr(8'h00, 32'h0000_0000);
    pulses(1'h0, 8'h22, 8'h03);
    chk({still, coil}, 6'h10);
    @(posedge clk_i);
    cnt_i <= 8'h01;
    go_i <= 1'h1;
    @(posedge clk_i);
    go_i <= 1'h0;
    for (k = 0; k < 200 && !step; k++) tick(1);
    t0 = cyc;
    m0 = ms;
    for (k = 0; k < 20 && ms == m0; k++) tick(1);
    m1 = ms;
    for (k = 0; k < 20 && ms == m1; k++) tick(1);
    chk(k, 4);
    tick(80);
    chk(ms, m0 + 10'h010);
    upto(500);
    chk(still, 1'h0);
    upto(530);
    chk({still, coil}, 6'h28);
    // Fast standstill timeout
    wr(8'h00, 32'h0000_0001);
    pulses(1'h0, 8'h04, 8'h01);
    t0 = cyc;
    tick(4);
    chk(still, 1'h0);
    upto(110);
    chk(still, 1'h0);
    upto(140);
    chk({still, coil}, 6'h28);
    // Diagnostic sources on the pins
    wr(8'h00, 32'h0000_0104);
    @(posedge clk_i) stall_i <= 1'h1;
    tick(3);
    chk({p1, p1_oe}, 2'h3);
    @(posedge clk_i) stall_i <= 1'h0;
    tick(3);
    chk({p1, p1_oe}, 2'h1);
    wr(8'h00, 32'h0000_0082);
    tick(2);
    m1[0] = p0;
    for (k = 1; k < 3; k++)
    begin
      @(posedge clk_i) skip_i <= 1'h1;
      @(posedge clk_i) skip_i <= 1'h0;
      tick(3);
      chk(p0, m1[0] ^ k[0]);
    end
    wr(8'h00, 32'h0000_0042);
    @(posedge clk_i) chop_i <= 1'h1;
    tick(3);
    chk(p0, 1'h1);
    @(posedge clk_i) chop_i <= 1'h0;
    tick(3);
    chk(p0, 1'h0);
    // Second reset, now in motion controller mode
    @(posedge clk_i) sel_i <= 1'h0;
    wr(8'h00, 32'h0000_0022);
    @(posedge clk_i) rst_n_i <= 1'h0;
    tick(3);
    chk({p0, p0_oe, ms, coil, still}, {2'h1, 10'h000, 5'h1F, 1'h0});
    tick(13);
    @(posedge clk_i) rst_n_i <= 1'h1;
    // Pin zero must not let go for even one cycle after the release
    for (k = 0; k < 8; k++)
    begin
      tick(1);
      chk({p0, p0_oe}, 2'h1);
    end
    rd(8'h04, d);
    chk(d, 32'h0000_0001);
    rd(8'h08, d);
    chk(d, 32'h0000_081F);
    rd(8'h0C, d);
    chk(d & 32'h0000_0006, 32'h0000_0006);
    wr(8'h0C, 32'h0000_0006);
    rd(8'h0C, d);
    chk(d & 32'h0000_0006, 32'h0000_0000);
    chk(p0_oe, 1'h0);
    @(posedge clk_i) cmp_i <= 1'h1;
    @(posedge clk_i) cmp_i <= 1'h0;
    tick(3);
    chk({p0, p0_oe}, 2'h1);
    @(posedge clk_i) irq_i <= 1'h1;
    tick(4);
    chk({p1, p1_oe}, 2'h1);
    report_and_stop();
  end
endmodule
